//--- common/rsv_pkg.sv
// package: build constants, register map and field arithmetic for the variable reed-solomon encoder
package rsv_pkg;

  // build-time code shape; the field follows the symbol width
  localparam int SYM_W = 8;
  localparam logic [SYM_W:0] FIELD_POLY = 9'h11d;
  localparam int FIRST_ROOT_POWER = 0;
  localparam int MAX_N = (1 << SYM_W) - 1;
  localparam int MAX_R = 40;
  localparam int MIN_N = 3;
  localparam int MIN_R = 4;
  localparam int RW = 6;

  // register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_CNT = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_PARAM = 4'hc;

  // field positions
  localparam int F_N_LSB = 0;
  localparam int F_R_LSB = 16;
  localparam int F_PEND = 24;
  localparam int F_ERR = 25;
  localparam int F_LOAD = 26;
  localparam int F_CHK = 27;
  localparam int F_ROOT_LSB = 24;

  // values after reset
  localparam logic [SYM_W-1:0] RST_N = 8'hcc;
  localparam logic [RW-1:0] RST_R = 6'h10;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // multiply in the field given by FIELD_POLY
  function automatic logic [SYM_W-1:0] gf_mul(input logic [SYM_W-1:0] a, input logic [SYM_W-1:0] b);
    logic [SYM_W-1:0] p;
    logic [SYM_W-1:0] x;
    p = '0;
    x = a;
    for (int i = 0; i < SYM_W; i++) begin
      if (b[i]) begin
        p = p ^ x;
      end
      x = x[SYM_W-1] ? ((x << 1) ^ FIELD_POLY[SYM_W-1:0]) : (x << 1); // R8
    end
    return p;
  endfunction

  // alpha raised to a constant power
  function automatic logic [SYM_W-1:0] gf_pow(input int e);
    logic [SYM_W-1:0] r;
    r = SYM_W'(1);
    for (int i = 0; i < e; i++) begin
      r = gf_mul(r, SYM_W'(2));
    end
    return r;
  endfunction

  localparam logic [SYM_W-1:0] ALPHA = SYM_W'(2);
  localparam logic [SYM_W-1:0] ROOT0 = gf_pow(FIRST_ROOT_POWER);

  typedef enum logic [1:0] {ST_LOAD, ST_DATA, ST_CHECK} rsv_state_type;

endpackage

//--- src/rsv_genpoly.sv
// generator polynomial builder: one root factor multiplied in per clock
`timescale 1ns/1ps
module rsv_genpoly import rsv_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic start,
  input wire logic [RW-1:0] r_cnt,
  output logic busy,
  output logic [MAX_R-1:0][SYM_W-1:0] coef
);

  logic [MAX_R:0][SYM_W-1:0] g_r;
  logic [MAX_R:0][SYM_W-1:0] g_nxt;
  logic [SYM_W-1:0] root_r;
  logic [SYM_W-1:0] root_nxt;
  logic [RW-1:0] left_r;
  logic [RW-1:0] left_nxt;

  // g(x) starts at 1 and takes (x + alpha^i) for consecutive i from the first root
  always_comb begin
    g_nxt = g_r;
    root_nxt = root_r;
    left_nxt = left_r;
    if (start) begin
      g_nxt = '0;
      g_nxt[0] = SYM_W'(1);
      root_nxt = ROOT0; // R9
      left_nxt = r_cnt;
    end else if (left_r != '0) begin
      g_nxt[0] = gf_mul(root_r, g_r[0]); // R3
      for (int j = 1; j <= MAX_R; j++) begin
        g_nxt[j] = g_r[j-1] ^ gf_mul(root_r, g_r[j]); // R3
      end
      root_nxt = gf_mul(root_r, ALPHA); // R9
      left_nxt = left_r - RW'(1);
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      g_r <= '0;
      root_r <= '0;
      left_r <= '0;
    end else if (ce) begin
      g_r <= g_nxt;
      root_r <= root_nxt;
      left_r <= left_nxt;
    end
  end

  assign busy = (left_r != '0);
  assign coef = g_r[MAX_R-1:0]; // leading 1 of g(x) is implied
endmodule

//--- src/rsv_axil.sv
// axi4-lite slave front end: turns bus transfers into register strobes
`timescale 1ns/1ps
module rsv_axil import rsv_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic reg_wr,
  output logic [ADDR_W-1:0] reg_waddr,
  output logic [31:0] reg_wdata,
  output logic [3:0] reg_wstrb,
  input wire logic reg_wok,
  output logic [ADDR_W-1:0] reg_raddr,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rok
);

  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r;

  // address and data are held separately, so either may arrive first
  always_comb begin
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    s_axi_awready = ce & ~aw_full_r;
    s_axi_wready = ce & ~w_full_r;
    s_axi_arready = ce & ~rvalid_r;
    reg_wr = ce & aw_full_r & w_full_r & ~bvalid_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (reg_wr) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = reg_wok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = reg_rok ? reg_rdata : 32'h0;
      rresp_nxt = reg_rok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // bus state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (ce) begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r & ce;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r & ce;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign reg_waddr = awaddr_r;
  assign reg_wdata = wdata_r;
  assign reg_wstrb = wstrb_r;
  assign reg_raddr = s_axi_araddr;
endmodule

//--- src/rsv_encoder.sv
// variable-length systematic reed-solomon encoder with axi4-lite configuration
// Overview of operation
// (R1) codeword length and check count change at run time by register write
// (R2) hardware sized for largest length and check count; software picks active values
// (R3) check symbols from generator product of (x - alpha^i) over consecutive roots
// (R4) one symbol per clock out, no latency between input and output
// (R5) codeword length must lie from three to two^width minus one
// (R6) check count from four to length minus one, never above forty
// (R7) symbol width is a build parameter, four to ten bits, sizing all paths
// (R8) field multiplications use the build-time field polynomial
// (R9) first root exponent is a build parameter; later roots follow consecutively
// (R10) information symbols pass unchanged first, then the check symbols
// (R11) new settings take effect only at the next codeword start
// (R12) first, last and check-symbol cycles are flagged on the output
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module rsv_encoder import rsv_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [SYM_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [SYM_W-1:0] out_data,
  output logic out_first,
  output logic out_last,
  output logic out_check
);

  logic reg_wr;
  logic [ADDR_W-1:0] reg_waddr;
  logic [31:0] reg_wdata;
  logic [3:0] reg_wstrb;
  logic reg_wok;
  logic [ADDR_W-1:0] reg_raddr;
  logic [31:0] reg_rdata;
  logic reg_rok;

  logic [SYM_W-1:0] cfg_n_r, cfg_n_nxt, act_n_r, act_n_nxt;
  logic [RW-1:0] cfg_r_r, cfg_r_nxt, act_r_r, act_r_nxt;
  logic pend_r, pend_nxt, err_r, err_nxt;
  logic [31:0] cfg_word, wr_val;
  logic [SYM_W-1:0] wr_n;
  logic [RW-1:0] wr_r;

  rsv_state_type state_r, state_nxt;
  logic [SYM_W-1:0] pos_r, pos_nxt;
  logic [MAX_R-1:0][SYM_W-1:0] par_r, par_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic commit, fire, gen_busy, cnt_clr;
  logic [SYM_W-1:0] fb, k_len, top_par; // R7
  logic [MAX_R-1:0][SYM_W-1:0] coef;

  // bus front end
  rsv_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .reg_wr(reg_wr),
    .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata),
    .reg_wstrb(reg_wstrb),
    .reg_wok(reg_wok),
    .reg_raddr(reg_raddr),
    .reg_rdata(reg_rdata),
    .reg_rok(reg_rok)
  );

  // generator coefficients rebuilt on every settings change
  rsv_genpoly u_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .start(commit),
    .r_cnt(cfg_r_r),
    .busy(gen_busy),
    .coef(coef)
  );

  // byte-lane merge of a write into the current register image
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        v[8*b +: 8] = d[8*b +: 8];
      end
    end
    return v;
  endfunction

  // legal code shape check
  function automatic logic shape_ok(input logic [SYM_W-1:0] n, input logic [RW-1:0] r);
    logic ok_n;
    logic ok_r;
    ok_n = (32'(n) >= MIN_N) && (32'(n) <= MAX_N); // R5
    ok_r = (32'(r) >= MIN_R) && (32'(r) <= MAX_R) && (32'(r) < 32'(n)); // R6
    return ok_n & ok_r;
  endfunction

  always_comb begin
    cfg_word = '0;
    cfg_word[F_N_LSB +: SYM_W] = cfg_n_r;
    cfg_word[F_R_LSB +: RW] = cfg_r_r;
  end

  // address decode for the bus front end
  assign reg_wok = (reg_waddr == ADDR_CFG) || (reg_waddr == ADDR_CNT);
  assign reg_rok = (reg_raddr == ADDR_CFG) || (reg_raddr == ADDR_STAT) ||
                   (reg_raddr == ADDR_CNT) || (reg_raddr == ADDR_PARAM);
  assign cnt_clr = reg_wr && (reg_waddr == ADDR_CNT);

  // read mux; unused bits read as zero
  always_comb begin
    reg_rdata = '0;
    case (reg_raddr)
      ADDR_CFG: begin
        reg_rdata = cfg_word;
      end
      ADDR_STAT: begin
        reg_rdata[F_N_LSB +: SYM_W] = act_n_r;
        reg_rdata[F_R_LSB +: RW] = act_r_r;
        reg_rdata[F_PEND] = pend_r;
        reg_rdata[F_ERR] = err_r;
        reg_rdata[F_LOAD] = (state_r == ST_LOAD);
        reg_rdata[F_CHK] = (state_r == ST_CHECK);
      end
      ADDR_CNT: begin
        reg_rdata = cnt_r;
      end
      ADDR_PARAM: begin
        reg_rdata[F_N_LSB +: SYM_W] = SYM_W'(MAX_N);
        reg_rdata[F_R_LSB +: RW] = RW'(MAX_R);
        reg_rdata[F_ROOT_LSB +: 8] = 8'(FIRST_ROOT_POWER);
      end
      default: begin
        reg_rdata = '0;
      end
    endcase
  end

  // settings written by software are held as pending until a codeword boundary
  always_comb begin
    cfg_n_nxt = cfg_n_r;
    cfg_r_nxt = cfg_r_r;
    pend_nxt = pend_r;
    err_nxt = err_r;
    wr_val = wmerge(cfg_word, reg_wdata, reg_wstrb);
    wr_n = wr_val[F_N_LSB +: SYM_W];
    wr_r = wr_val[F_R_LSB +: RW];
    if (commit) begin
      pend_nxt = 1'b0;
    end
    // a write landing on the commit cycle stays pending, so it is never lost
    if (reg_wr && (reg_waddr == ADDR_CFG)) begin
      if (shape_ok(wr_n, wr_r)) begin // R2
        cfg_n_nxt = wr_n;
        cfg_r_nxt = wr_r;
        pend_nxt = 1'b1; // R1
        err_nxt = 1'b0;
      end else begin
        err_nxt = 1'b1; // R5 R6
      end
    end
  end

  // settings registers; reset leaves a pending default so the first coefficients get built
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_n_r <= RST_N;
      cfg_r_r <= RST_R;
      pend_r <= 1'b1;
      err_r <= 1'b0;
    end else if (ce) begin
      cfg_n_r <= cfg_n_nxt;
      cfg_r_r <= cfg_r_nxt;
      pend_r <= pend_nxt;
      err_r <= err_nxt;
    end
  end

  // stream handshake: information symbols go straight through, check symbols come from the lfsr
  always_comb begin
    k_len = act_n_r - SYM_W'(act_r_r);
    top_par = par_r[act_r_r - RW'(1)];
    commit = (state_r == ST_DATA) && (pos_r == '0) && pend_r; // R11
    in_ready = 1'b0;
    out_valid = 1'b0;
    out_data = in_data; // R10
    out_first = 1'b0;
    out_last = 1'b0;
    out_check = 1'b0;
    case (state_r)
      ST_DATA: begin
        in_ready = ce & out_ready & ~commit; // R4
        out_valid = ce & in_valid & ~commit; // R4
        out_first = (pos_r == '0); // R12
      end
      ST_CHECK: begin
        out_valid = ce;
        out_data = top_par; // R10
        out_check = 1'b1; // R12
        out_last = (pos_r == act_n_r - SYM_W'(1)); // R12
      end
      default: begin
        out_valid = 1'b0;
      end
    endcase
    fire = out_valid & out_ready;
  end

  // codeword sequencing and the parity register; the lfsr length follows the active check count
  always_comb begin
    state_nxt = state_r;
    pos_nxt = pos_r;
    par_nxt = par_r;
    act_n_nxt = act_n_r;
    act_r_nxt = act_r_r;
    cnt_nxt = cnt_clr ? 32'h0 : cnt_r;
    fb = in_data ^ top_par;
    case (state_r)
      ST_DATA: begin
        if (commit) begin
          act_n_nxt = cfg_n_r; // R11
          act_r_nxt = cfg_r_r; // R11
          par_nxt = '0;
          state_nxt = ST_LOAD;
        end else if (fire) begin
          par_nxt[0] = gf_mul(fb, coef[0]); // R3
          for (int j = 1; j < MAX_R; j++) begin
            par_nxt[j] = par_r[j-1] ^ gf_mul(fb, coef[j]); // R3
          end
          pos_nxt = pos_r + SYM_W'(1);
          if (pos_r == k_len - SYM_W'(1)) begin
            state_nxt = ST_CHECK; // R10
          end
        end
      end
      ST_LOAD: begin
        // input waits while the generator is rebuilt for the new check count
        if (!gen_busy) begin
          state_nxt = ST_DATA;
        end
      end
      ST_CHECK: begin
        if (fire) begin
          par_nxt[0] = '0;
          for (int j = 1; j < MAX_R; j++) begin
            par_nxt[j] = par_r[j-1];
          end
          if (out_last) begin
            pos_nxt = '0;
            state_nxt = ST_DATA;
            cnt_nxt = cnt_nxt + 32'h1; // a same-cycle clear applies first, then the completion still counts
          end else begin
            pos_nxt = pos_r + SYM_W'(1);
          end
        end
      end
      default: begin
        state_nxt = ST_DATA;
      end
    endcase
  end

  // stream state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_DATA;
      pos_r <= '0;
      par_r <= '0;
      act_n_r <= RST_N;
      act_r_r <= RST_R;
      cnt_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      pos_r <= pos_nxt;
      par_r <= par_nxt;
      act_n_r <= act_n_nxt;
      act_r_r <= act_r_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

//--- test/rsv_encoder_properties.sv
// checker: bus and stream properties of the encoder
`timescale 1ns/1ps
module rsv_encoder_properties import rsv_pkg::*; (
  input logic aclk,
  input logic aresetn,
  input logic ce,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic in_valid,
  input logic in_ready,
  input logic [SYM_W-1:0] in_data,
  input logic out_valid,
  input logic out_ready,
  input logic [SYM_W-1:0] out_data,
  input logic out_first,
  input logic out_last,
  input logic out_check
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [6:0] chk_cnt_r, chk_cnt_nxt;
  // check symbols delivered in this codeword
  always_comb begin
    chk_cnt_nxt = chk_cnt_r;
    if (out_valid && out_ready && out_check) begin
      chk_cnt_nxt = out_last ? 7'h00 : chk_cnt_r + 7'h01;
    end
  end
  always_ff @(posedge aclk) begin
    chk_cnt_r <= aresetn ? chk_cnt_nxt : 7'h00;
  end
  pass_thru_a: assert property (in_valid && in_ready |-> out_valid && out_data == in_data && !out_check)
    else $error("info symbol not passed through");
  check_stall_a: assert property (out_valid && out_check |-> !in_ready)
    else $error("input taken during check phase");
  last_frame_a: assert property (out_valid && out_last |-> out_check && !out_first)
    else $error("last flag outside check symbols");
  first_frame_a: assert property (out_valid && out_ready && out_first |-> !out_check && in_ready)
    else $error("first flag not on an info symbol");
  check_hold_a: assert property (ce && out_valid && out_check && !out_ready |=>
    !ce || (out_valid && out_check && $stable(out_data)))
    else $error("stalled check symbol changed");
  check_count_a: assert property (out_valid && out_check |-> chk_cnt_r < 7'h28)
    else $error("too many check symbols");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  bresp_hold_a: assert property (ce && s_axi_bvalid && !s_axi_bready |=> !ce || (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
endmodule
bind rsv_encoder rsv_encoder_properties chk_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
  .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_first(out_first),
  .out_last(out_last), .out_check(out_check));

//--- test/rsv_stream_partner.sv
// stream partner: symbol source and stalling sink
`timescale 1ns/1ps
module rsv_stream_partner import rsv_pkg::*; (
  input logic aclk,
  input logic slow,
  input logic in_ready,
  output logic in_valid,
  output logic [SYM_W-1:0] in_data,
  output logic out_ready
);
  initial begin
    in_valid = 1'b0;
    in_data = 8'h00;
    out_ready = 1'b1;
  end
  // sink stalls at random when slow
  always @(posedge aclk) begin
    out_ready <= slow ? 1'($urandom) : 1'b1;
  end
  // valid stays up inside a codeword: no drop and rise in one step
  task automatic send(input logic [SYM_W-1:0] d, input logic last, output bit ok);
    int t;
    in_valid <= 1'b1;
    in_data <= d;
    for (t = 0; t < 500; t++) begin
      @(posedge aclk);
      if (in_ready === 1'b1) break;
    end
    ok = (t < 500);
    if (last) begin
      in_valid <= 1'b0;
      in_data <= ~d; // released data shows no stale symbol
      @(posedge aclk);
    end
  endtask
endmodule

//--- test/tb_rsv_encoder.sv
// testbench: registers, framing and check symbols
`timescale 1ns/1ps
module tb_rsv_encoder import rsv_pkg::*;;
  logic aclk, aresetn, ce, slow;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic in_valid, in_ready, out_valid, out_ready, out_first, out_last, out_check;
  logic [SYM_W-1:0] in_data, out_data;
  logic [SYM_W+2:0] exp_q [$];
  int n_errors;
  int total_checks;
  int ncw;
  int good_n [4] = '{7, 5, 41, 255};
  int good_r [4] = '{4, 4, 40, 40};
  int bad_n [4] = '{200, 200, 6, 2};
  int bad_r [4] = '{3, 41, 6, 4};
  rsv_encoder dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_first(out_first),
    .out_last(out_last), .out_check(out_check));
  rsv_stream_partner pm_u (.aclk(aclk), .slow(slow), .in_ready(in_ready), .in_valid(in_valid),
    .in_data(in_data), .out_ready(out_ready));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic check(input string what, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    test_done();
  endtask
  // independent msb-first field multiply
  function automatic logic [SYM_W-1:0] gm(input logic [SYM_W-1:0] a, b);
    logic [SYM_W-1:0] p;
    p = 8'h00;
    for (int i = SYM_W - 1; i >= 0; i--) begin
      p = p[SYM_W-1] ? ((p << 1) ^ FIELD_POLY[SYM_W-1:0]) : (p << 1);
      if (b[i]) p = p ^ a;
    end
    return p;
  endfunction
  function automatic logic [31:0] cw(input int n, input int r);
    return (32'(n) << F_N_LSB) | (32'(r) << F_R_LSB);
  endfunction
  // bus master: bready follows bvalid, so each response waits one cycle
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] rsp);
    int t;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) break;
      s_axi_bready <= s_axi_bvalid;
    end
    if (t == 100) hang();
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] m, e, input string w);
    int t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (t == 100) hang();
    check(w, s_axi_rdata & m, e);
    check("rresp", 32'(s_axi_rresp), 32'(RESP_OKAY));
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wr_chk(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] rsp;
    axi_wr(a, d, rsp);
    check("bresp", 32'(rsp), 32'(e));
  endtask
  // one codeword; expectations from an lfsr model
  task automatic send_cw(input int n, input int r);
    logic [SYM_W-1:0] g [0:MAX_R];
    logic [SYM_W-1:0] p [0:MAX_R-1];
    logic [SYM_W-1:0] d [$];
    logic [SYM_W-1:0] rt, fb;
    bit ok;
    g[0] = 8'h01;
    rt = 8'h01;
    for (int i = 0; i < FIRST_ROOT_POWER; i++) rt = gm(rt, 8'h02);
    for (int i = 0; i < r; i++) begin
      g[i + 1] = 8'h00;
      for (int j = i + 1; j > 0; j--) g[j] = g[j - 1] ^ gm(g[j], rt);
      g[0] = gm(g[0], rt);
      rt = gm(rt, 8'h02);
    end
    for (int j = 0; j < r; j++) p[j] = 8'h00;
    for (int i = 0; i < n - r; i++) begin
      d.push_back(SYM_W'($urandom));
      exp_q.push_back({i == 0, 2'b00, d[i]});
      fb = d[i] ^ p[r - 1];
      for (int j = r - 1; j > 0; j--) p[j] = p[j - 1] ^ gm(fb, g[j]);
      p[0] = gm(fb, g[0]);
    end
    for (int j = r - 1; j >= 0; j--) exp_q.push_back({1'b0, j == 0, 1'b1, p[j]});
    for (int i = 0; i < n - r; i++) begin
      pm_u.send(d[i], i == n - r - 1, ok);
      if (!ok) hang();
    end
    ncw++;
  endtask
  task automatic drain();
    for (int t = 0; t < 1000 && exp_q.size() > 0; t++) @(posedge aclk);
    if (exp_q.size() > 0) hang();
  endtask
  // watcher: each delivered symbol meets the oldest note
  always @(posedge aclk) begin
    if (aresetn === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("spare symbol", 32'h1, 32'h0);
      end else begin
        check("symbol", 32'({out_first, out_last, out_check, out_data}), 32'(exp_q.pop_front()));
      end
    end
  end
  initial begin
    logic [1:0] rsp;
    void'($urandom(90536));
    aresetn = 1'b0;
    ce = 1'b1;
    slow = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(ADDR_PARAM, 32'hff3f00ff, cw(MAX_N, MAX_R) | (32'(FIRST_ROOT_POWER) << F_ROOT_LSB), "param");
    rd_chk(ADDR_CFG, 32'h003f00ff, cw(int'(RST_N), int'(RST_R)), "cfg after reset");
    send_cw(int'(RST_N), int'(RST_R));
    for (int i = 0; i < 4; i++) begin
      axi_wr(ADDR_CFG, cw(bad_n[i], bad_r[i]), rsp);
      rd_chk(ADDR_STAT, 32'h1 << F_ERR, 32'h1 << F_ERR, "reject flag");
      rd_chk(ADDR_CFG, 32'h003f00ff, cw(int'(RST_N), int'(RST_R)), "cfg kept");
    end
    // settings change while the last check symbols leave
    for (int i = 0; i < 4; i++) begin
      slow <= i[0];
      wr_chk(ADDR_CFG, cw(good_n[i], good_r[i]), RESP_OKAY);
      send_cw(good_n[i], good_r[i]);
      send_cw(good_n[i], good_r[i]);
    end
    drain();
    slow <= 1'b0;
    wr_chk(ADDR_CFG, cw(20, 4), RESP_OKAY);
    fork
      send_cw(20, 4);
      begin
        repeat (10) @(posedge aclk);
        wr_chk(ADDR_CFG, cw(10, 6), RESP_OKAY);
      end
    join
    send_cw(10, 6);
    drain();
    rd_chk(ADDR_STAT, 32'h033f00ff, cw(10, 6), "active settings");
    wr_chk(ADDR_STAT, 32'h0, RESP_SLVERR);
    wr_chk(ADDR_PARAM, 32'h0, RESP_SLVERR);
    rd_chk(ADDR_CNT, 32'hffffffff, 32'(ncw), "codewords");
    wr_chk(ADDR_CNT, 32'h0, RESP_OKAY);
    rd_chk(ADDR_CNT, 32'hffffffff, 32'h0, "count cleared");
    test_done();
  end
endmodule
